/* hdl/pmp_cfg.svh */
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH
// Reference clock rate of the control domain in kHz
`define PMP_REF_CLK_KHZ     10000
// Divider half periods, in reference cycles, for the generated clocks
`define PMP_HALF_100M       1
`define PMP_HALF_10M        10
// Reduced interface hold count at 10 Mbps
`define PMP_RMII_HOLD_10M   10
// Reset values
`define PMP_RST_STRAP       1'b0
`define PMP_RST_NIBBLE      4'h0
`endif

/* hdl/pmp_pkg.sv */
package pmp_pkg;
   typedef enum logic [1:0] {PMP_MII, PMP_RMII_MASTER, PMP_RMII_SLAVE}
      pmp_mode_t;
   typedef enum logic {PMP_SPEED_10, PMP_SPEED_100} pmp_speed_t;
   typedef enum logic [1:0] {PMP_RX_IDLE, PMP_RX_FRAME} pmp_rx_state_t;
endpackage

/* hdl/pmp_port.sv */
`timescale 1ns/10ps
`include "pmp_cfg.svh"
// How it works
// RL1 - Management clock at most 25 MHz; the test model's MDC toggles every 7.5 ns, about 66.7 MHz
// RL2 - Management logic runs on its own clock
// RL3 - Data line shared, driven one side
// RL4 - Receive data aligned, valid with valid flag
// RL5 - Four bits MII, two bits reduced
// RL6 - Valid pin merges carrier in reduced mode
// RL7 - Receive clock 25 or 2.5 MHz; the divider gives 5 or 0.5 MHz from the 10000 kHz reference
// RL8 - Reduced master outputs reference clock
// RL9 - Reference clock chosen by mode
// RL10 - Error flag raised on error symbol
// RL11 - Error flag raised also in idle
// RL12 - Strap caught at power-up only
// RL13 - Shared pin defaults to power-down input
// RL14 - Shared pin open-drain interrupt output
// RL15 - Transmit clock 25 or 2.5 MHz; the divider gives 5 or 0.5 MHz from the 10000 kHz reference
// RL16 - Line paths follow chosen speed
// RL17 - MAC drives transmit enable high
// RL18 - Reduced transmit data on reference clock
// RL19 - Collision only half duplex, both busy
// RL20 - Carrier sense when either busy
// RL21 - Reduced 10 Mbps holds ten cycles
module pmp_port
(
   // Clock and reset
   input  wire logic               ref_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               power_up_in,
   // Configuration
   input  wire pmp_pkg::pmp_mode_t mode_in,
   input  wire pmp_pkg::pmp_speed_t speed_in,
   input  wire logic               full_duplex_in,
   input  wire logic               int_enable_in,
   input  wire logic               int_event_in,
   // Line side decoded symbols
   input  wire logic               line_rx_valid_in,
   input  wire logic               line_rx_carrier_in,
   input  wire logic               line_rx_error_in,
   input  wire logic [3:0]         line_rx_data_in,
   input  wire logic               line_tx_active_in,
   // Receive, transmit clock and status pins
   output logic [3:0]              rx_data_out,
   output logic                    rx_valid_out,
   output logic                    rx_error_out,
   output logic                    rx_clk_out,
   output logic                    rx_clk_oe_out,
   output logic                    tx_clk_out,
   output logic                    col_out,
   output logic                    crs_out,
   // Strap
   input  wire logic               error_pin_bootstrap_in,
   output logic                    error_pin_bootstrap_out,
   // Shared interrupt or power-down pin
   input  wire logic               int_pin_in,
   output logic                    int_pin_out,
   output logic                    int_pin_oe_out,
   output logic                    power_down_out,
   // Management
   input  wire logic               mdc_clk_in,
   input  wire logic               mdc_rst_n_in,
   input  wire logic               mdio_in,
   input  wire logic               mdio_drive_in,
   input  wire logic               mdio_bit_in,
   output logic                    mdio_out,
   output logic                    mdio_oe_out,
   output logic                    mdio_sample_out
);

   function automatic logic [4:0] half_period(input pmp_pkg::pmp_speed_t s);
      half_period = (s == pmp_pkg::PMP_SPEED_100) ? 5'(`PMP_HALF_100M)
                                                  : 5'(`PMP_HALF_10M);
   endfunction

   logic [4:0]            div_cnt_reg;
   logic                  gen_clk_reg;
   logic                  int_s1_reg;
   logic                  int_s2_reg;
   logic                  strap_s1_reg;
   logic                  strap_s2_reg;
   logic                  strap_done_reg;
   logic [3:0]            hold_cnt_reg;
   pmp_pkg::pmp_rx_state_t rx_state_reg;
   logic                  is_mii;
   logic                  is_rmii;

   assign is_mii  = (mode_in == pmp_pkg::PMP_MII);
   assign is_rmii = !is_mii;

   // RL7 RL15 RL16 clock divider
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         div_cnt_reg <= 5'h00;
         gen_clk_reg <= 1'b0;
      end
      else if (div_cnt_reg + 5'h01 >= half_period(speed_in))
      begin
         div_cnt_reg <= 5'h00;
         gen_clk_reg <= !gen_clk_reg;
      end
      else
         div_cnt_reg <= div_cnt_reg + 5'h01;
   end

   // RL15 transmit clock fixed phase
   assign tx_clk_out = is_mii & gen_clk_reg;
   // RL8 RL9 receive clock pin role
   assign rx_clk_out    = (mode_in == pmp_pkg::PMP_RMII_MASTER) ? ref_clk_in
                        : (is_mii & gen_clk_reg);
   assign rx_clk_oe_out = (mode_in != pmp_pkg::PMP_RMII_SLAVE);

   // RL21 reduced hold counter
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in || is_mii || speed_in == pmp_pkg::PMP_SPEED_100)
         hold_cnt_reg <= 4'h0;
      else if (hold_cnt_reg == 4'(`PMP_RMII_HOLD_10M - 1))
         hold_cnt_reg <= 4'h0;
      else
         hold_cnt_reg <= hold_cnt_reg + 4'h1;
   end

   // Frame tracking
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         rx_state_reg <= pmp_pkg::PMP_RX_IDLE;
      else
         case (rx_state_reg)
            pmp_pkg::PMP_RX_IDLE:
               if (line_rx_valid_in)
                  rx_state_reg <= pmp_pkg::PMP_RX_FRAME;
            pmp_pkg::PMP_RX_FRAME:
               if (!line_rx_valid_in)
                  rx_state_reg <= pmp_pkg::PMP_RX_IDLE;
            default:
               rx_state_reg <= pmp_pkg::PMP_RX_IDLE;
         endcase
   end

   // RL4 RL5 RL6 receive outputs
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         rx_data_out  <= `PMP_RST_NIBBLE;
         rx_valid_out <= 1'b0;
      end
      else if (hold_cnt_reg == 4'h0)
      begin
         rx_data_out  <= line_rx_valid_in ?
                         (is_mii ? line_rx_data_in
                                 : {2'b00, line_rx_data_in[1:0]})
                         : `PMP_RST_NIBBLE;
         rx_valid_out <= is_mii ? line_rx_valid_in
                                : (line_rx_valid_in | line_rx_carrier_in);
      end
   end

   // RL10 RL11 receive error in frame and idle
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
         rx_error_out <= 1'b0;
      else
         rx_error_out <= line_rx_error_in;
   end

   // RL19 RL20 collision and carrier
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         col_out <= 1'b0;
         crs_out <= 1'b0;
      end
      else
      begin
         col_out <= is_mii & !full_duplex_in & line_tx_active_in
                    & line_rx_carrier_in;
         crs_out <= is_mii & (line_tx_active_in | line_rx_carrier_in);
      end
   end

   // Strap pin synchroniser
   always_ff @(posedge ref_clk_in)
   begin
      strap_s1_reg <= error_pin_bootstrap_in;
      strap_s2_reg <= strap_s1_reg;
   end

   // RL12 strap captured at power-up only
   always_ff @(posedge ref_clk_in)
   begin
      if (power_up_in)
      begin
         strap_done_reg          <= 1'b0;
         error_pin_bootstrap_out <= `PMP_RST_STRAP;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg          <= 1'b1;
         error_pin_bootstrap_out <= strap_s2_reg;
      end
   end

   // Shared pin synchroniser
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         int_s1_reg <= 1'b1;
         int_s2_reg <= 1'b1;
      end
      else
      begin
         int_s1_reg <= int_pin_in;
         int_s2_reg <= int_s1_reg;
      end
   end

   // RL13 RL14 power-down input or open-drain interrupt
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         power_down_out <= 1'b0;
         int_pin_oe_out <= 1'b0;
      end
      else
      begin
         power_down_out <= !int_enable_in & !int_s2_reg;
         int_pin_oe_out <= int_enable_in & int_event_in;
      end
   end
   assign int_pin_out = 1'b0;

   // RL2 RL3 management pin on its own clock
   always_ff @(posedge mdc_clk_in)
   begin
      if (!mdc_rst_n_in)
      begin
         mdio_out        <= 1'b1;
         mdio_oe_out     <= 1'b0;
         mdio_sample_out <= 1'b1;
      end
      else
      begin
         mdio_out        <= mdio_bit_in;
         mdio_oe_out     <= mdio_drive_in;
         mdio_sample_out <= mdio_in;
      end
   end

   a_col_half_dup: assert property (@(posedge ref_clk_in) // RL19
      disable iff (!rst_n_in) col_out |-> $past(!full_duplex_in && is_mii))
      else $error("collision outside half duplex");
   a_crs_busy: assert property (@(posedge ref_clk_in) // RL20
      disable iff (!rst_n_in)
      $past(rst_n_in && is_mii && line_tx_active_in) |-> crs_out)
      else $error("carrier sense missed");
   a_err_follow: assert property (@(posedge ref_clk_in) // RL10
      disable iff (!rst_n_in) line_rx_error_in |=> rx_error_out)
      else $error("receive error missed");
   a_err_idle: assert property (@(posedge ref_clk_in) // RL11
      disable iff (!rst_n_in)
      (line_rx_error_in && !line_rx_valid_in) |=> rx_error_out)
      else $error("idle error missed");
   a_pd_default: assert property (@(posedge ref_clk_in) // RL13
      disable iff (!rst_n_in) int_pin_oe_out |-> $past(int_enable_in))
      else $error("shared pin driven while disabled");
   a_int_low: assert property (@(posedge ref_clk_in) // RL14
      disable iff (!rst_n_in)
      (int_enable_in && int_event_in) |=> int_pin_oe_out)
      else $error("interrupt not driven");
   a_rmii_narrow: assert property (@(posedge ref_clk_in) // RL5
      disable iff (!rst_n_in)
      (is_rmii && $stable(mode_in)) |=> rx_data_out[3:2] == 2'b00)
      else $error("upper bits used in reduced mode");
   a_rxclk_slave: assert property (@(posedge ref_clk_in) // RL8
      disable iff (!rst_n_in) (mode_in == pmp_pkg::PMP_RMII_SLAVE) |->
      (!rx_clk_oe_out && !rx_clk_out))
      else $error("receive clock driven as slave");
   a_strap_hold: assert property (@(posedge ref_clk_in) // RL12
      disable iff (power_up_in) (strap_done_reg && !rst_n_in) |=>
      $stable(error_pin_bootstrap_out))
      else $error("strap recaptured on reset");
   a_rx_follow: assert property (@(posedge ref_clk_in) // RL4
      disable iff (!rst_n_in)
      $past(rst_n_in && is_mii && line_rx_valid_in && hold_cnt_reg == 4'h0)
      |-> (rx_valid_out && rx_data_out == $past(line_rx_data_in)))
      else $error("receive nibble not presented");
   a_crs_dv_merge: assert property (@(posedge ref_clk_in) // RL6
      disable iff (!rst_n_in)
      $past(rst_n_in && is_rmii && line_rx_carrier_in && hold_cnt_reg == 4'h0)
      |-> rx_valid_out)
      else $error("carrier not merged into valid");

   c_frame: cover property (@(posedge ref_clk_in)
      rx_state_reg == pmp_pkg::PMP_RX_FRAME ##1
      rx_state_reg == pmp_pkg::PMP_RX_IDLE);
   c_collision: cover property (@(posedge ref_clk_in) col_out);
   c_power_down: cover property (@(posedge ref_clk_in) power_down_out);
   c_mdio_drive: cover property (@(posedge mdc_clk_in) mdio_oe_out);

endmodule

/* test/pmp_mac_model.sv */
`timescale 1ns/10ps
module pmp_mac_model
(
   // Frame and station drive
   input  wire logic frame_en_in,
   input  wire logic st_oe_in,
   input  wire logic st_bit_in,
   // Device drive of the data line
   input  wire logic dev_oe_in,
   input  wire logic dev_bit_in,
   // Management lines
   output logic      mdc_out,
   output logic      mdio_out
);
   initial
   begin
      mdc_out = 1'b0;
      #3;
      forever
      begin
         #7.5;
         mdc_out = frame_en_in ? ~mdc_out : 1'b0;
      end
   end
   assign mdio_out = st_oe_in ? st_bit_in : (dev_oe_in ? dev_bit_in : 1'b1);
endmodule

/* test/pmp_port_test.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
`define WAITV(s, v) begin k = 0; while ((s) !== (v) && k < 60) begin \
   @(negedge ref_clk_in); k++; end if (k == 60) begin n_fail++; \
   print_verdict; end @(negedge ref_clk_in); end
module pmp_port_test;
   logic                ref_clk_in = 1'b0;
   logic                rst_n_in = 1'b0;
   logic                pwr, fd, ie, iev, lv, lc, le, ltx, strap, pin;
   logic                frm, so, sb, md, mb, mrst;
   pmp_pkg::pmp_mode_t  mode;
   pmp_pkg::pmp_speed_t spd;
   logic [3:0]          ld, rxd;
   logic                rxv, rxe, rxc, rxoe, txc, col, crs, sto, ipo, ipoe;
   logic                pd, mo, moe, msmp, mdc, mdio;
   wire                 ipw;
   int                  n_fail = 0;
   int                  n_compared = 0;
   int                  k, cr, ct, cd;
   assign ipw = ipoe ? 1'b0 : pin;
   always #50 ref_clk_in = ~ref_clk_in;
   initial
   begin
      repeat (3000) @(posedge ref_clk_in);
      n_fail++;
      print_verdict;
   end
   pmp_port u_pmp_port (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .power_up_in(pwr), .mode_in(mode), .speed_in(spd),
      .full_duplex_in(fd), .int_enable_in(ie), .int_event_in(iev),
      .line_rx_valid_in(lv), .line_rx_carrier_in(lc),
      .line_rx_error_in(le), .line_rx_data_in(ld), .line_tx_active_in(ltx),
      .rx_data_out(rxd), .rx_valid_out(rxv), .rx_error_out(rxe),
      .rx_clk_out(rxc), .rx_clk_oe_out(rxoe), .tx_clk_out(txc),
      .col_out(col), .crs_out(crs), .error_pin_bootstrap_in(strap),
      .error_pin_bootstrap_out(sto), .int_pin_in(ipw), .int_pin_out(ipo),
      .int_pin_oe_out(ipoe), .power_down_out(pd), .mdc_clk_in(mdc),
      .mdc_rst_n_in(mrst), .mdio_in(mdio), .mdio_drive_in(md),
      .mdio_bit_in(mb), .mdio_out(mo), .mdio_oe_out(moe),
      .mdio_sample_out(msmp));
   pmp_mac_model u_pmp_mac_model (.frame_en_in(frm), .st_oe_in(so),
      .st_bit_in(sb), .dev_oe_in(moe), .dev_bit_in(mo), .mdc_out(mdc),
      .mdio_out(mdio));
   task print_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task edges(input int n);
      repeat (n) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask
   task set_cfg(input pmp_pkg::pmp_mode_t m, input pmp_pkg::pmp_speed_t s);
      @(posedge ref_clk_in);
      mode <= m;
      spd <= s;
   endtask
   task run;
      logic       pr, pt;
      logic [3:0] pq;
      cr = 0;
      ct = 0;
      cd = 0;
      @(negedge ref_clk_in);
      pr = rxc;
      pt = txc;
      pq = rxd;
      repeat (40)
      begin
         @(posedge ref_clk_in);
         ld <= ld + 4'h1;
         @(negedge ref_clk_in);
         cr += int'(rxc !== pr);
         ct += int'(txc !== pt);
         cd += int'(rxd !== pq);
         pr = rxc;
         pt = txc;
         pq = rxd;
      end
   endtask
   initial
   begin
      {pwr, strap, pin} = 3'h7;
      {fd, ie, iev, lv, lc, le, ltx, frm, so, sb, md, mb, mrst} = '0;
      ld = 4'h0;
      mode = pmp_pkg::PMP_MII;
      spd = pmp_pkg::PMP_SPEED_100;
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      pwr <= 1'b0;
      edges(2);
      `CHK("rx_valid", 1'b0, rxv)
      `CHK("strap", 1'b1, sto)
      @(posedge ref_clk_in);
      strap <= 1'b0;
      rst_n_in <= 1'b0;
      @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      edges(2);
      `CHK("strap kept", 1'b1, sto)
      @(posedge ref_clk_in);
      {lv, ld} <= 5'h1A;
      edges(1);
      `CHK("rx_data", 4'hA, rxd)
      `CHK("rx_valid", 1'b1, rxv)
      @(posedge ref_clk_in);
      {lv, le} <= 2'h1;
      edges(1);
      `CHK("idle error", 1'b1, rxe)
      @(posedge ref_clk_in);
      lv <= 1'b1;
      edges(1);
      `CHK("frame error", 1'b1, rxe)
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk_in);
         {fd, lc, ltx} <= 3'(i);
         edges(1);
         `CHK("col", ~fd & lc & ltx, col)
         `CHK("crs", lc | ltx, crs)
      end
      set_cfg(pmp_pkg::PMP_RMII_MASTER, pmp_pkg::PMP_SPEED_100);
      {lv, le, lc, ld} <= 7'h1F;
      edges(1);
      `CHK("crs_dv", 1'b1, rxv)
      `CHK("rmii crs", 1'b0, crs)
      `CHK("clk oe", 1'b1, rxoe)
      @(posedge ref_clk_in);
      lv <= 1'b1;
      edges(1);
      `CHK("rmii data", 4'h3, rxd)
      set_cfg(pmp_pkg::PMP_RMII_SLAVE, pmp_pkg::PMP_SPEED_100);
      edges(2);
      `CHK("slave oe", 1'b0, rxoe)
      `CHK("slave clk", 1'b0, rxc)
      set_cfg(pmp_pkg::PMP_RMII_MASTER, pmp_pkg::PMP_SPEED_10);
      run;
      run;
      `CHK("hold 10", 4, cd)
      `CHK("tx clk rmii", 0, ct)
      `CHK("upper bits", 2'h0, rxd[3:2])
      set_cfg(pmp_pkg::PMP_MII, pmp_pkg::PMP_SPEED_10);
      run;
      run;
      `CHK("rx clk 10", 4, cr)
      `CHK("tx clk 10", 4, ct)
      set_cfg(pmp_pkg::PMP_MII, pmp_pkg::PMP_SPEED_100);
      run;
      run;
      `CHK("rx clk 100", 40, cr)
      `CHK("tx clk 100", 40, ct)
      @(posedge ref_clk_in);
      pin <= 1'b0;
      `WAITV(pd, 1'b1)
      `CHK("power down", 1'b1, pd)
      @(posedge ref_clk_in);
      {pin, ie, iev} <= 3'h7;
      `WAITV(ipoe, 1'b1)
      `CHK("int pin", 1'b0, ipw)
      `CHK("int out", 1'b0, ipo)
      `CHK("no power down", 1'b0, pd)
      @(posedge ref_clk_in);
      iev <= 1'b0;
      `WAITV(ipoe, 1'b0)
      frm = 1'b1;
      repeat (3) @(posedge mdc);
      mrst <= 1'b1;
      repeat (2) @(negedge mdc);
      `CHK("mdio oe reset", 1'b0, moe)
      for (int i = 0; i < 2; i++)
      begin
         @(negedge mdc);
         {so, sb} = {1'b1, i[0]};
         repeat (4) @(negedge mdc);
         `CHK("mdio sample", i[0], msmp)
      end
      @(posedge mdc);
      so <= 1'b0;
      {md, mb} <= 2'h2;
      repeat (4) @(negedge mdc);
      `CHK("mdio oe", 1'b1, moe)
      `CHK("mdio line", 1'b0, mdio)
      @(posedge mdc);
      md <= 1'b0;
      repeat (4) @(negedge mdc);
      `CHK("mdio pull-up", 1'b1, mdio)
      frm = 1'b0;
      print_verdict;
   end
endmodule
